// [stc_clk_sel.sv]
// Counter clock source selection producing a one-cycle count tick.
`default_nettype none
`include "stc_consts.svh"

module stc_clk_sel
	import stc_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [2:0] clock_source_select_in,
	input wire logic sub_clk_in,
	input wire logic external_count_input_in,
	output logic tick_out,
	output logic ext_rise_out
);

	// The high clock is taken as the system clock, so both share one prescaler.
	logic [5:0] pre_r;
	logic sub_prev_r;
	logic ext_prev_r;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pre_r <= '0;
			sub_prev_r <= 1'b0;
			ext_prev_r <= 1'b0;
		end else begin
			pre_r <= pre_r + 6'h01;
			sub_prev_r <= sub_clk_in;
			ext_prev_r <= external_count_input_in;
		end
	end

	assign ext_rise_out = external_count_input_in & ~ext_prev_r;

	always_comb begin
		case (clock_source_select_in) // R2
			`STC_CK_SYS4: tick_out = ((pre_r & `STC_DIV4_MASK) == `STC_DIV4_MASK);
			`STC_CK_SYS: tick_out = 1'b1;
			`STC_CK_H16: tick_out = ((pre_r & `STC_DIV16_MASK) == `STC_DIV16_MASK);
			`STC_CK_H64: tick_out = (pre_r == `STC_DIV64_MASK);
			`STC_CK_SUB0, `STC_CK_SUB1: tick_out = sub_clk_in & ~sub_prev_r;
			`STC_CK_EXT_R: tick_out = external_count_input_in & ~ext_prev_r;
			`STC_CK_EXT_F: tick_out = ~external_count_input_in & ext_prev_r;
			default: tick_out = 1'b0;
		endcase
	end

endmodule // stc_clk_sel

`default_nettype wire

// [stc_consts.svh]
// Register offsets, field codes, reset values and clock divider counts of the standard timer.
//
// Notes on behaviour
// [R1] Hold bit freezes counter, resume from value.
// [R2] Clock field picks divided, sub or external clocks.
// [R3] Run bit set counts, clear stops module.
// [R4] Run rising edge zeroes counter; falling keeps.
// [R5] Run rising edge restores initial pin level.
// [R6] Control zero bits two to zero read zero.
// [R7] Mode field: compare, PWM/pulse, timer.
// [R8] Software stops module before changing mode.
// [R9] Timer mode ignores level and invert bits.
// [R10] Compare match A: keep, low, high, toggle.
// [R11] PWM modes: inactive, active, PWM, single pulse.
// [R12] Requested level equal initial shows no change.
// [R13] Software changes pin action only when off.
// [R14] Level bit: initial or active level.
// [R15] Invert bit inverts the output pin.
// [R16] Swap bit exchanges PWM period and duty sources.
// [R17] Clear source: A match, or P/overflow.
// [R18] Overflow clear only when period value zero.
// [R19] PWM and pulse modes ignore clear source.
// [R20] Period value times 256 clocks, zero 65536.
// [R21] Compare A high byte read write, reset zero.
// [R22] Low byte write buffered until high byte write.
// [R23] High byte read latches low byte buffer.
// [R24] Sixteen bit up counter, full A compare.
// [R25] Count each active edge while running, unheld.
`ifndef STC_CONSTS_SVH
`define STC_CONSTS_SVH

`define STC_OFF_CNT_LO 8'h00
`define STC_OFF_CNT_HI 8'h04
`define STC_OFF_CMPA_LO 8'h08
`define STC_OFF_CMPA_HI 8'h0C
`define STC_OFF_CTRL0 8'h10
`define STC_OFF_CTRL1 8'h14
`define STC_OFF_PERIOD 8'h18

`define STC_RST_BYTE 8'h00
`define STC_CTRL0_RSVD_MASK 8'h07

`define STC_MODE_CMP 2'b00
`define STC_MODE_PWM 2'b10
`define STC_MODE_TMR 2'b11
`define STC_MODE_UNDEF 2'b01

`define STC_ACT_KEEP 2'b00
`define STC_ACT_LOW 2'b01
`define STC_ACT_HIGH 2'b10
`define STC_ACT_TOGGLE 2'b11

`define STC_CK_SYS4 3'b000
`define STC_CK_SYS 3'b001
`define STC_CK_H16 3'b010
`define STC_CK_H64 3'b011
`define STC_CK_SUB0 3'b100
`define STC_CK_SUB1 3'b101
`define STC_CK_EXT_R 3'b110
`define STC_CK_EXT_F 3'b111

`define STC_DIV4_MASK 6'h03
`define STC_DIV16_MASK 6'h0F
`define STC_DIV64_MASK 6'h3F

`endif

// [stc_far_model.sv]
// Far-side model: sub clock, external count input and a meter of pin high time.
`default_nettype none

module stc_far_model (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ext_en_in,
	input wire logic clr_in,
	input wire logic pin_in,
	output logic sub_clk_out,
	output logic ext_out,
	output logic [15:0] high_cnt_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] div_r;

	// The sub clock runs free; the count input stays low unless a burst is requested.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			div_r <= 5'h00;
			ext_out <= 1'b0;
			high_cnt_out <= 16'h0000;
		end else begin
			div_r <= div_r + 5'h01;
			ext_out <= ext_en_in & div_r[3];
			high_cnt_out <= clr_in ? 16'h0000 : high_cnt_out + 16'(pin_in);
		end
	end
	assign sub_clk_out = div_r[4];
endmodule // stc_far_model

`default_nettype wire

// [stc_pkg.sv]
// Types shared by the standard timer modules.
`default_nettype none

package stc_pkg;

	typedef struct packed {
		logic counter_hold;
		logic [2:0] clock_source_select;
		logic run_enable;
		logic [2:0] unused;
	} stc_ctrl0_t;

	typedef struct packed {
		logic [1:0] operating_mode_field;
		logic [1:0] pin_action_select;
		logic output_level_control;
		logic output_invert;
		logic period_duty_swap;
		logic clear_source_select;
	} stc_ctrl1_t;

endpackage : stc_pkg

`default_nettype wire

// [stc_timer.sv]
// Standard timer: APB register file, 16-bit counter, comparators and output pin logic.
`default_nettype none
`include "stc_consts.svh"

module stc_timer
	import stc_pkg::*;
#(
	parameter int ADDR_W = 8
)(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic sub_clk_in,
	input wire logic external_count_input_in,
	output logic timer_output_pin_out
);

	////////////////////////////////////////////////////////////////////////////
	// Register state.

	stc_ctrl0_t ctrl0_r;
	stc_ctrl1_t ctrl1_r;
	logic [7:0] period_compare_value_r;
	logic [15:0] compare_a_value_r;
	logic [7:0] buf_r;
	logic [15:0] cnt_r;
	logic run_prev_r;
	logic pin_r;
	logic pin_nxt;
	logic out_r;
	logic [31:0] prdata_r;

	logic setup;
	logic wr_acc;
	logic rd_setup;
	logic addr_hit;
	logic [7:0] rd_val;
	logic tick;
	logic ext_rise;

	logic run;
	logic hold;
	logic run_rise;
	logic is_cmp;
	logic is_pwm;
	logic is_single;
	logic counting;
	logic [15:0] cnt_inc;
	logic a_hit;
	logic p_hit;
	logic cnt_clr;
	logic duty_act;
	logic sw_c0_wr;
	logic sp_trig;
	logic sp_end;

	////////////////////////////////////////////////////////////////////////////
	// APB slave: zero wait states, read data captured in the setup cycle.

	assign setup = psel_in & ~penable_in;
	assign wr_acc = psel_in & penable_in & pwrite_in;
	assign rd_setup = setup & ~pwrite_in;
	assign pready_out = 1'b1;
	assign pslverr_out = psel_in & penable_in & ~addr_hit;
	assign prdata_out = prdata_r;

	always_comb begin
		rd_val = `STC_RST_BYTE;
		addr_hit = 1'b1;
		case (paddr_in)
			// Low bytes read through the shared buffer.
			`STC_OFF_CNT_LO: rd_val = buf_r; // R23
			`STC_OFF_CNT_HI: rd_val = cnt_r[15:8];
			`STC_OFF_CMPA_LO: rd_val = buf_r; // R23
			`STC_OFF_CMPA_HI: rd_val = compare_a_value_r[15:8]; // R21
			`STC_OFF_CTRL0: rd_val = ctrl0_r & ~`STC_CTRL0_RSVD_MASK | 8'h00; // R6
			`STC_OFF_CTRL1: rd_val = ctrl1_r;
			`STC_OFF_PERIOD: rd_val = period_compare_value_r;
			default: addr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prdata_r <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata_r <= {24'h00_0000, rd_val};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Byte buffer shared by the low-byte accesses.

	// The latch on a high-byte read happens in the setup cycle, the same cycle in which the
	// high byte is captured, so the two halves always come from one counter value.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			buf_r <= `STC_RST_BYTE;
		end else if (wr_acc && paddr_in == `STC_OFF_CMPA_LO) begin
			buf_r <= pwdata_in[7:0]; // R22
		end else if (rd_setup && paddr_in == `STC_OFF_CNT_HI) begin
			buf_r <= cnt_r[7:0]; // R23
		end else if (rd_setup && paddr_in == `STC_OFF_CMPA_HI) begin
			buf_r <= compare_a_value_r[7:0]; // R23
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			compare_a_value_r <= 16'h0000;
		end else if (wr_acc && paddr_in == `STC_OFF_CMPA_HI) begin
			compare_a_value_r <= {pwdata_in[7:0], buf_r}; // R21 R22
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl1_r <= stc_ctrl1_t'(`STC_RST_BYTE);
		end else if (wr_acc && paddr_in == `STC_OFF_CTRL1) begin
			ctrl1_r <= stc_ctrl1_t'(pwdata_in[7:0]);
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			period_compare_value_r <= `STC_RST_BYTE;
		end else if (wr_acc && paddr_in == `STC_OFF_PERIOD) begin
			period_compare_value_r <= pwdata_in[7:0];
		end
	end

	// A software write wins over the single-pulse hardware set and clear, and a hardware
	// trigger wins over a match that ends the pulse in the same cycle.
	assign sw_c0_wr = wr_acc && paddr_in == `STC_OFF_CTRL0;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl0_r <= stc_ctrl0_t'(`STC_RST_BYTE);
		end else if (sw_c0_wr) begin
			ctrl0_r <= stc_ctrl0_t'(pwdata_in[7:0] & ~`STC_CTRL0_RSVD_MASK); // R6
		end else if (sp_trig) begin
			ctrl0_r.run_enable <= 1'b1;
		end else if (sp_end) begin
			ctrl0_r.run_enable <= 1'b0; // R11
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Counter and comparators.

	stc_clk_sel u_clk_sel (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.clock_source_select_in(ctrl0_r.clock_source_select),
		.sub_clk_in(sub_clk_in),
		.external_count_input_in(external_count_input_in),
		.tick_out(tick),
		.ext_rise_out(ext_rise)
	);

	assign run = ctrl0_r.run_enable;
	assign hold = ctrl0_r.counter_hold;
	assign run_rise = run & ~run_prev_r;
	assign is_cmp = ctrl1_r.operating_mode_field == `STC_MODE_CMP; // R7
	assign is_pwm = ctrl1_r.operating_mode_field == `STC_MODE_PWM; // R7
	assign is_single = is_pwm && ctrl1_r.pin_action_select == `STC_ACT_TOGGLE;
	assign counting = tick & run & ~hold; // R1 R3 R25
	assign cnt_inc = cnt_r + 16'h0001;
	// A zero compare A value never matches; the counter then just wraps.
	assign a_hit = counting && compare_a_value_r != 16'h0000 && cnt_inc == compare_a_value_r; // R24
	// P sets only the top byte of the compare value, the low byte being zero, so a match lands on a multiple of 256 counts.
	assign p_hit = counting && period_compare_value_r != 8'h00
		&& cnt_inc == {period_compare_value_r, 8'h00}; // R20
	assign sp_trig = is_single & ext_rise & ~run;
	assign sp_end = is_single & a_hit;

	always_comb begin
		if (is_single) begin
			cnt_clr = 1'b0; // R19
		end else if (is_pwm) begin
			cnt_clr = ctrl1_r.period_duty_swap ? a_hit : p_hit; // R16 R19
		end else begin
			cnt_clr = ctrl1_r.clear_source_select ? a_hit : p_hit; // R17
		end
	end

	// With the period value at zero no P match exists and the counter wraps at its top.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_r <= 16'h0000;
		end else if (run_rise) begin
			cnt_r <= 16'h0000; // R4
		end else if (cnt_clr) begin
			cnt_r <= 16'h0000; // R17
		end else if (counting) begin
			cnt_r <= cnt_inc; // R18 R25
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			run_prev_r <= 1'b0;
		end else begin
			run_prev_r <= run;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output pin.

	always_comb begin
		if (ctrl1_r.period_duty_swap) begin
			duty_act = period_compare_value_r == 8'h00
				|| cnt_r < {period_compare_value_r, 8'h00}; // R16
		end else begin
			duty_act = cnt_r < compare_a_value_r; // R16
		end
	end

	always_comb begin
		pin_nxt = 1'b0;
		if (is_cmp) begin
			pin_nxt = pin_r;
			if (run_rise) begin
				pin_nxt = ctrl1_r.output_level_control; // R5 R14
			end else if (a_hit) begin
				case (ctrl1_r.pin_action_select) // R10 R12
					`STC_ACT_LOW: pin_nxt = 1'b0;
					`STC_ACT_HIGH: pin_nxt = 1'b1;
					`STC_ACT_TOGGLE: pin_nxt = ~pin_r;
					default: pin_nxt = pin_r;
				endcase
			end
		end else if (is_pwm) begin
			case (ctrl1_r.pin_action_select) // R11 R14
				`STC_ACT_KEEP: pin_nxt = ~ctrl1_r.output_level_control;
				`STC_ACT_LOW: pin_nxt = ctrl1_r.output_level_control;
				`STC_ACT_HIGH: pin_nxt = (run & duty_act) ~^ ctrl1_r.output_level_control;
				default: pin_nxt = run ~^ ctrl1_r.output_level_control;
			endcase
		end
	end

	// Timer mode leaves the pin low; level and invert bits do not reach it there.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pin_r <= 1'b0;
			out_r <= 1'b0;
		end else begin
			pin_r <= pin_nxt;
			out_r <= pin_nxt ^ (ctrl1_r.output_invert & (is_cmp | is_pwm)); // R9 R15
		end
	end

	assign timer_output_pin_out = out_r;

	////////////////////////////////////////////////////////////////////////////
	// Assertions.

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	property p_hold_freeze;
		run && hold && !run_rise |=> cnt_r == $past(cnt_r);
	endproperty
	a_hold_freeze: assert property (p_hold_freeze) else $error("counter moved on hold"); // R1

	property p_off_stop;
		!run ##1 !run |-> $stable(cnt_r);
	endproperty
	a_off_stop: assert property (p_off_stop) else $error("counter moved while off"); // R3

	property p_run_rise_zero;
		run_rise |=> cnt_r == 16'h0000 ##1 (cnt_r <= 16'h0001);
	endproperty
	a_run_rise_zero: assert property (p_run_rise_zero) else $error("no clear on run edge"); // R4

	property p_init_level;
		is_cmp && run_rise |=> out_r == (ctrl1_r.output_level_control ^ ctrl1_r.output_invert);
	endproperty
	a_init_level: assert property (p_init_level) else $error("pin not at initial level"); // R5

	property p_ctrl0_low;
		rd_setup && paddr_in == `STC_OFF_CTRL0 |=> prdata_out[2:0] == 3'b000;
	endproperty
	a_ctrl0_low: assert property (p_ctrl0_low) else $error("reserved bits nonzero"); // R6

	property p_timer_pin;
		ctrl1_r.operating_mode_field == `STC_MODE_TMR ##1 $stable(ctrl1_r) |-> !out_r;
	endproperty
	a_timer_pin: assert property (p_timer_pin) else $error("pin driven in timer mode"); // R9

	property p_cmp_high;
		is_cmp && a_hit && !run_rise && ctrl1_r.pin_action_select == `STC_ACT_HIGH
			|=> pin_r && timer_output_pin_out == !ctrl1_r.output_invert;
	endproperty
	a_cmp_high: assert property (p_cmp_high) else $error("match did not drive high"); // R10 R15

	property p_single_end;
		is_single && a_hit && !sw_c0_wr |=> !run ##1 !pin_r == ctrl1_r.output_level_control;
	endproperty
	a_single_end: assert property (p_single_end) else $error("pulse did not end"); // R11

	property p_clear_src;
		!is_pwm && !run_rise && (ctrl1_r.clear_source_select ? a_hit : p_hit)
			|=> cnt_r == 16'h0000;
	endproperty
	a_clear_src: assert property (p_clear_src) else $error("counter not cleared"); // R17

	property p_count_step;
		counting && !cnt_clr && !run_rise |=> cnt_r == $past(cnt_r) + 16'h0001;
	endproperty
	a_count_step: assert property (p_count_step) else $error("counter did not step"); // R25

	property p_cmpa_pair;
		wr_acc && paddr_in == `STC_OFF_CMPA_HI
			|=> compare_a_value_r == {$past(pwdata_in[7:0]), $past(buf_r)};
	endproperty
	a_cmpa_pair: assert property (p_cmpa_pair) else $error("compare A pair lost"); // R22

	property p_cnt_latch;
		rd_setup && paddr_in == `STC_OFF_CNT_HI |=> buf_r == $past(cnt_r[7:0]);
	endproperty
	a_cnt_latch: assert property (p_cnt_latch) else $error("low byte not latched"); // R23

	// With no match possible at the top value the counter must roll over to zero.
	property p_wrap;
		counting && !run_rise && cnt_r == 16'hFFFF |=> cnt_r == 16'h0000;
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter did not wrap"); // R18

	property p_undef_mode;
		ctrl1_r.operating_mode_field == `STC_MODE_UNDEF ##1 $stable(ctrl1_r) |-> !out_r;
	endproperty
	a_undef_mode: assert property (p_undef_mode) else $error("pin driven in undefined mode"); // R7

	c_p_clear: cover property (is_cmp && p_hit ##1 cnt_r == 16'h0000);
	c_pwm_run: cover property (is_pwm && run && duty_act ##1 !duty_act);
	c_single: cover property (sp_trig ##[1:300] sp_end);
	c_wrap: cover property (counting && cnt_r == 16'hFFFF);

endmodule // stc_timer

`default_nettype wire

// [stc_timer_test.sv]
// Self-checking testbench of the standard timer.
`default_nettype none
`include "stc_consts.svh"

module stc_timer_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in, rst_n_in, psel, pen, pwr, pready, pslverr, sub_clk, ext, pin, ext_en, clr, err;
	logic [7:0] paddr, v;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] hi_cnt, cv, c0;
	int n_fail, samples_checked, seed, i;
	int divs [8] = '{4, 1, 16, 64, 32, 32, 16, 16};
	logic [7:0] offs [4] = '{`STC_OFF_CTRL0, `STC_OFF_CTRL1, `STC_OFF_PERIOD, `STC_OFF_CMPA_HI};
	logic [7:0] pc1 [6] = '{8'hA9, 8'hAA, 8'hA1, 8'hAD, 8'h89, 8'h99};
	logic [15:0] pa [6] = '{16'h0040, 16'h0200, 16'h0040, 16'h0040, 16'h0040, 16'h0040};
	int ph [6] = '{128, 256, 384, 384, 0, 512};

	stc_timer i_stc_timer (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.psel_in(psel),
		.penable_in(pen),
		.pwrite_in(pwr),
		.paddr_in(paddr),
		.pwdata_in(pwdata),
		.prdata_out(prdata),
		.pready_out(pready),
		.pslverr_out(pslverr),
		.sub_clk_in(sub_clk),
		.external_count_input_in(ext),
		.timer_output_pin_out(pin)
	);

	stc_far_model i_stc_far_model (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.ext_en_in(ext_en),
		.clr_in(clr),
		.pin_in(pin),
		.sub_clk_out(sub_clk),
		.ext_out(ext),
		.high_cnt_out(hi_cnt)
	);

	////////////////////////////////////////
	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic near(input string nm, input logic [31:0] s, input int e, input int t);
		chk(nm, {31'h0, (s + 32'(t) >= 32'(e)) && (s <= 32'(e + t))}, 32'h1);
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk_in);
		pen <= 1'b1;
		do @(posedge clk_in); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task automatic setcmp(input logic [15:0] a);
		apb(1'b1, `STC_OFF_CMPA_LO, a[7:0]);
		apb(1'b1, `STC_OFF_CMPA_HI, a[15:8]);
	endtask

	// Mode and pin action change only while the module is off.
	task automatic run(input logic [7:0] c1, input logic [2:0] ck);
		apb(1'b1, `STC_OFF_CTRL0, {1'b0, ck, 4'h0});
		apb(1'b1, `STC_OFF_CTRL1, c1);
		apb(1'b1, `STC_OFF_CTRL0, {1'b0, ck, 4'h8});
	endtask

	task automatic getcnt(output logic [15:0] c);
		apb(1'b0, `STC_OFF_CNT_HI, 8'h00);
		c[15:8] = rd[7:0];
		apb(1'b0, `STC_OFF_CNT_LO, 8'h00);
		c[7:0] = rd[7:0];
	endtask

	task automatic spin(input logic [7:0] c1, input logic [2:0] ck, input int n);
		run(c1, ck);
		wt(n);
		apb(1'b1, `STC_OFF_CTRL0, {1'b0, ck, 4'h0});
		getcnt(cv);
	endtask

	function automatic logic cmp_pin(input logic [1:0] act, input logic oc);
		case (act)
			2'b00: return oc;
			2'b01: return 1'b0;
			2'b10: return 1'b1;
			default: return ~oc;
		endcase
	endfunction

	////////////////////////////////////////
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end

	// The tests take about 10k cycles; five times that means a hang.
	initial begin
		#250_000;
		n_fail++;
		stop_test();
	end

	initial begin
		seed = 95;
		n_fail = 0;
		samples_checked = 0;
		{rst_n_in, psel, pen, pwr, ext_en, clr} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (3) @(posedge clk_in);
		rst_n_in <= 1'b1;
		for (i = 0; i < 8; i++) begin
			apb(1'b0, 8'(i * 4), 8'h00);
			chk("reset", {err, pready, rd[29:0]}, {i == 7, 1'b1, 30'h0});
		end
		for (i = 0; i < 16; i++) begin
			// Random control writes keep the run bit clear, so mode changes happen while off.
			v = 8'($random(seed)) & ((i % 4 == 0) ? 8'hF7 : 8'hFF);
			apb(1'b1, offs[i % 4], v);
			apb(1'b0, offs[i % 4], 8'h00);
			chk("rw", rd, {24'h0, (i % 4 == 0) ? (v & 8'hF8) : v});
		end
		run(8'hC0, 3'b001);
		apb(1'b1, `STC_OFF_PERIOD, 8'h00);
		$display("registers done");
		c0 = 16'($random(seed));
		setcmp(c0);
		apb(1'b1, `STC_OFF_CMPA_LO, ~c0[7:0]);
		apb(1'b0, `STC_OFF_CMPA_HI, 8'h00);
		chk("cmpa_hi", rd, 32'(c0[15:8]));
		apb(1'b0, `STC_OFF_CMPA_LO, 8'h00);
		chk("cmpa_lo", rd, 32'(c0[7:0]));
		$display("buffer done");
		run(8'hC0, 3'b001);
		wt(40);
		apb(1'b1, `STC_OFF_CTRL0, 8'h98);
		getcnt(c0);
		wt(20);
		getcnt(cv);
		chk("hold", 32'(cv), 32'(c0));
		apb(1'b1, `STC_OFF_CTRL0, 8'h18);
		wt(20);
		getcnt(cv);
		near("resume", 32'(cv), int'(c0) + 20, 5);
		apb(1'b1, `STC_OFF_CTRL0, 8'h10);
		getcnt(c0);
		wt(20);
		getcnt(cv);
		chk("stop", 32'(cv), 32'(c0));
		apb(1'b1, `STC_OFF_CTRL0, 8'h18);
		getcnt(cv);
		near("restart", 32'(cv), 2, 2);
		ext_en <= 1'b1;
		for (i = 0; i < 8; i++) begin
			spin(8'hC0, 3'(i), 256);
			near("clk_src", 32'(cv), 256 / divs[i] + 2, 6);
		end
		ext_en <= 1'b0;
		$display("counter done");
		setcmp(16'h0010);
		for (i = 0; i < 16; i++) begin
			run({2'b00, 2'(i), i[2], i[3], 2'b01}, 3'b001);
			wt(6);
			chk("cmp_init", 32'(pin), 32'(i[2] ^ i[3]));
			wt(18);
			chk("cmp_match", 32'(pin), 32'(cmp_pin(2'(i), i[2]) ^ i[3]));
		end
		run(8'hCC, 3'b001);
		wt(40);
		chk("tmr_pin", 32'(pin), 32'h0);
		$display("compare done");
		apb(1'b1, `STC_OFF_PERIOD, 8'h01);
		for (i = 0; i < 6; i++) begin
			setcmp(pa[i]);
			run(pc1[i], 3'b001);
			wt(8);
			clr <= 1'b1;
			wt(1);
			clr <= 1'b0;
			wt(512);
			near("pwm_high", 32'(hi_cnt), ph[i], 6);
		end
		setcmp(16'h00C8);
		run(8'hB8, 3'b001);
		wt(4);
		chk("pulse_lead", 32'(pin), 32'h1);
		wt(220);
		chk("pulse_trail", 32'(pin), 32'h0);
		apb(1'b0, `STC_OFF_CTRL0, 8'h00);
		chk("pulse_run", 32'(rd[3]), 32'h0);
		ext_en <= 1'b1;
		wt(40);
		ext_en <= 1'b0;
		chk("pulse_trig", 32'(pin), 32'h1);
		$display("pwm done");
		spin(8'hC0, 3'b001, 600);
		chk("clr_p", {31'h0, cv < 16'h0100}, 32'h1);
		setcmp(16'h0064);
		spin(8'hC1, 3'b001, 600);
		chk("clr_a", {31'h0, cv < 16'h0064}, 32'h1);
		apb(1'b1, `STC_OFF_PERIOD, 8'h00);
		spin(8'hC0, 3'b001, 600);
		near("no_clr", 32'(cv), 602, 8);
		$display("clear done");
		stop_test();
	end
endmodule // stc_timer_test

`default_nettype wire
